// file: hdl/pmc_pkg.sv
/*
  pmc_pkg: constants, field positions, timing counts and types shared by the
  module-control-pin logic of the pluggable module.
  Assumes a single 100 MHz clock domain; all pins are synchronised before use.
*/
package pmc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_PULSE_NS  = 10000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_TIME_NS  = 2000;
  localparam int INIT_CYC      = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  // two-wire bus slave address, arbitrary neutral value
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // memory map
  localparam int         MAP_DEPTH  = 16;
  localparam int         PTR_W      = 4;
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_FLAGS  = 4'h1;
  localparam logic [3:0] ADR_CTRL   = 4'h2;
  localparam logic [3:0] ADR_POWER  = 4'h3;
  localparam logic [3:0] ADR_SCRATCH = 4'h4;

  // field positions
  localparam int BIT_DNR        = 0;
  localparam int FLG_RESET_DONE = 0;
  localparam int FLG_FAULT      = 1;
  localparam int NUM_FLAGS      = 2;
  localparam int CTL_HP_EN      = 0;
  localparam int PWR_HIGH       = 0;
  localparam int PWR_INIT_SW    = 1;

  // reset values
  localparam logic [7:0]           MEM_RST   = 8'h00;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 2'h0;
  localparam logic                 HP_EN_RST = 1'b0;

  // pin bundle, synchronised as one vector
  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_n;
    logic rst_n;
    logic init;
    logic init_drv;
  } pmc_pins_t;

  localparam logic [5:0] PINS_IDLE = 6'h3E;

  typedef struct packed {
    logic data_not_ready;
    logic high_power;
    logic init_sw;
  } pmc_status_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_INIT  = 2'b01,
    ST_READY = 2'b11
  } pmc_mgmt_t;

  typedef enum logic [2:0] {
    TW_IDLE  = 3'b000,
    TW_ADDR  = 3'b001,
    TW_AACK  = 3'b011,
    TW_WDATA = 3'b010,
    TW_WACK  = 3'b110,
    TW_RDATA = 3'b111,
    TW_RACK  = 3'b101
  } pmc_twi_t;

endpackage

// file: hdl/pmc_sync.sv
/*
  pmc_sync: two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; no bus coherence across bits is implied.
*/
`timescale 1ns/1ps
module pmc_sync #(
  parameter int              W       = 6,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // levels
  input  wire logic [W-1:0]  d_async,
  output logic      [W-1:0]  q_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q_sync <= RST_VAL;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule // pmc_sync

// file: hdl/pmc_pulse_filter.sv
/*
  pmc_pulse_filter: qualifies an active-low level; the output rises only once
  the input has stayed low for more than MIN_CYC cycles, and falls with it.
  Assumes a synchronised input.
*/
`timescale 1ns/1ps
module pmc_pulse_filter #(
  parameter int                  CNT_W   = 16,
  parameter logic [CNT_W-1:0]    MIN_CYC = 16'h03E8
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // level in, qualified level out
  input  wire logic              level_n,
  output logic                   active
);

  logic [CNT_W-1:0] cnt_r;

  // short glitches restart the count, so they never reach the output
  always_ff @(posedge clock) begin
    if (!rst_n || level_n) begin
      cnt_r  <= '0;
      active <= 1'b0;
    end else if (cnt_r < MIN_CYC) begin
      cnt_r  <= cnt_r + 1'b1;
    end else begin
      active <= 1'b1;
    end
  end

endmodule // pmc_pulse_filter

// file: hdl/pmc_ctrl.sv
/*
  pmc_ctrl: low-speed control-pin logic of the pluggable module: select-gated
  two-wire management slave with a small memory map, filtered host reset,
  reset-completion interrupt, init-mode power control, present and interrupt.
  Assumes the host provides pull-ups on the open-drain lines and resolves the
  wires from the enables; scl/sda arrive asynchronously.
*/
//
// Overview of operation
// - bus transactions answered only while module select is low
// - host reaches memory map over two-wire clock and data
// - qualified long reset low restores all settings to defaults
// - reset completion raises interrupt and clears the not-ready flag
// - power-up raises the completion interrupt without a reset pulse
// - undriven init-mode input reads high, selecting software control
// - init-mode high: stay low power until software enables high power
// - init-mode low: go high power once management init completes
// - module pulls present line low while inserted
// - interrupt line low signals fault or critical status
// - interrupt line is open-drain: pull low or release only
`timescale 1ns/1ps
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int MIN_PULSE = pmc_pkg::MIN_PULSE_CYC,
  parameter int INIT_TIME = pmc_pkg::INIT_CYC
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // two-wire management bus
  input  wire logic                 twi_scl,
  input  wire logic                 twi_sda_i,
  output logic                      twi_sda_o,
  output logic                      twi_sda_oe,
  // host control inputs
  input  wire logic                 module_select_n,
  input  wire logic                 module_reset_n,
  input  wire logic                 init_control_select,
  input  wire logic                 init_control_select_drv,
  // open-drain outputs to host
  output logic                      module_present_n_o,
  output logic                      module_present_n_oe,
  output logic                      interrupt_out_n_o,
  output logic                      interrupt_out_n_oe,
  // module-internal events and status
  input  wire logic                 fault_event,
  output pmc_pkg::pmc_status_t      status
);

  import pmc_pkg::*;

  localparam logic [CNT_W-1:0] MIN_PULSE_W = CNT_W'(MIN_PULSE);
  localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_TIME - 1);

  pmc_pins_t               pins_s;
  pmc_pins_t               pins_q;
  logic                    host_rst;
  logic                    sreset;
  logic                    init_eff;
  logic                    sel;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;

  pmc_mgmt_t               mgmt_r;
  logic [CNT_W-1:0]        init_cnt_r;
  logic                    done_pulse;

  logic [NUM_FLAGS-1:0]    flags_r;
  logic [NUM_FLAGS-1:0]    flags_nxt;
  logic                    int_oe_r;
  logic                    hp_en_r;
  logic                    hp_mode_r;
  logic [7:0]              mem_r [MAP_DEPTH];
  logic [7:0]              rd_byte;

  pmc_twi_t                tw_r;
  logic [2:0]              bit_cnt_r;
  logic                    byte_full_r;
  logic [7:0]              shift_r;
  logic [7:0]              tx_r;
  logic [PTR_W-1:0]        ptr_r;
  logic                    first_r;
  logic                    rw_r;
  logic                    acked_r;
  logic                    sda_oe_r;
  logic                    wr_pulse_r;
  logic [PTR_W-1:0]        wr_addr_r;
  logic [7:0]              wr_data_r;
  logic                    rd_done_r;
  logic [PTR_W-1:0]        rd_addr_r;

  // pins enter through two flops
  pmc_sync #(
    .W       (6),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .d_async ({twi_scl, twi_sda_i, module_select_n, module_reset_n,
               init_control_select, init_control_select_drv}),
    .q_sync  (pins_s)
  );

  pmc_pulse_filter #(
    .CNT_W   (CNT_W),
    .MIN_CYC (MIN_PULSE_W)
  ) u_rst_filt (
    .clock   (clock),
    .rst_n   (rst_n),
    .level_n (pins_s.rst_n),
    .active  (host_rst)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_q <= pmc_pins_t'(PINS_IDLE);
    end else begin
      pins_q <= pins_s;
    end
  end

  assign sreset    = !rst_n || host_rst;
  assign init_eff  = pins_s.init_drv ? pins_s.init : 1'b1;
  assign sel       = ~pins_s.sel_n;
  assign scl_rise  = pins_s.scl & ~pins_q.scl;
  assign scl_fall  = ~pins_s.scl & pins_q.scl;
  assign start_det = pins_s.scl & pins_q.scl & pins_q.sda & ~pins_s.sda;
  assign stop_det  = pins_s.scl & pins_q.scl & ~pins_q.sda & pins_s.sda;

  // management init sequence; power-up enters it the same as a host reset
  always_ff @(posedge clock) begin
    if (sreset) begin
      mgmt_r     <= ST_RESET;
      init_cnt_r <= '0;
    end else begin
      case (mgmt_r)
        ST_RESET: begin
          mgmt_r     <= ST_INIT;
          init_cnt_r <= '0;
        end
        ST_INIT: begin
          if (init_cnt_r >= INIT_LAST) begin
            mgmt_r <= ST_READY;
          end else begin
            init_cnt_r <= init_cnt_r + 1'b1;
          end
        end
        ST_READY: mgmt_r <= ST_READY;
        default:  mgmt_r <= ST_RESET;
      endcase
    end
  end

  assign done_pulse = (mgmt_r == ST_INIT) && (init_cnt_r >= INIT_LAST);

  // sticky flags; a set in the clearing cycle survives
  always_comb begin
    flags_nxt = flags_r;
    if (rd_done_r && rd_addr_r == ADR_FLAGS) begin
      flags_nxt = '0;
    end
    flags_nxt[FLG_RESET_DONE] = flags_nxt[FLG_RESET_DONE] | done_pulse;
    flags_nxt[FLG_FAULT]      = flags_nxt[FLG_FAULT] | fault_event;
  end

  always_ff @(posedge clock) begin
    if (sreset) begin
      flags_r  <= FLAGS_RST;
      int_oe_r <= 1'b0;
    end else begin
      flags_r  <= flags_nxt;
      int_oe_r <= |flags_nxt;
    end
  end

  // open drain: data is always zero, only the enable moves
  assign interrupt_out_n_o   = 1'b0;
  assign interrupt_out_n_oe  = int_oe_r;
  assign module_present_n_o  = 1'b0;
  assign module_present_n_oe = 1'b1;
  assign twi_sda_o           = 1'b0;
  assign twi_sda_oe          = sda_oe_r;

  // writable settings, all back to defaults on any reset
  always_ff @(posedge clock) begin
    if (sreset) begin
      hp_en_r <= HP_EN_RST;
      for (int i = 0; i < MAP_DEPTH; i++) begin
        mem_r[i] <= MEM_RST;
      end
    end else if (wr_pulse_r) begin
      if (wr_addr_r == ADR_CTRL) begin
        hp_en_r <= wr_data_r[CTL_HP_EN];
      end else if (wr_addr_r >= ADR_SCRATCH) begin
        mem_r[wr_addr_r] <= wr_data_r;
      end
    end
  end

  // power mode follows the init-mode choice
  always_ff @(posedge clock) begin
    if (sreset) begin
      hp_mode_r <= 1'b0;
    end else begin
      hp_mode_r <= (mgmt_r == ST_READY) && (!init_eff || hp_en_r);
    end
  end

  assign status.data_not_ready = (mgmt_r != ST_READY);
  assign status.high_power     = hp_mode_r;
  assign status.init_sw        = init_eff;

  // read view of the memory map
  always_comb begin
    rd_byte = 8'h00;
    case (ptr_r)
      ADR_STATUS: rd_byte[BIT_DNR]        = (mgmt_r != ST_READY);
      ADR_FLAGS:  rd_byte[NUM_FLAGS-1:0]  = flags_r;
      ADR_CTRL:   rd_byte[CTL_HP_EN]      = hp_en_r;
      ADR_POWER: begin
        rd_byte[PWR_HIGH]    = hp_mode_r;
        rd_byte[PWR_INIT_SW] = init_eff;
      end
      default:    rd_byte = mem_r[ptr_r];
    endcase
  end

  // two-wire slave engine; bits sampled on scl rise, sda moved on scl fall
  always_ff @(posedge clock) begin
    wr_pulse_r <= 1'b0;
    rd_done_r  <= 1'b0;
    if (sreset || !sel) begin
      tw_r        <= TW_IDLE;
      sda_oe_r    <= 1'b0;
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      ptr_r       <= '0;
      first_r     <= 1'b1;
      rw_r        <= 1'b0;
      acked_r     <= 1'b0;
      wr_addr_r   <= '0;
      wr_data_r   <= 8'h00;
      rd_addr_r   <= '0;
    end else if (start_det) begin
      tw_r        <= TW_ADDR;
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
      sda_oe_r    <= 1'b0;
      first_r     <= 1'b1;
    end else if (stop_det) begin
      tw_r     <= TW_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      case (tw_r)
        TW_ADDR, TW_WDATA: begin
          shift_r     <= {shift_r[6:0], pins_s.sda};
          bit_cnt_r   <= bit_cnt_r + 3'h1;
          byte_full_r <= (bit_cnt_r == 3'h7);
        end
        TW_RDATA: begin
          bit_cnt_r   <= bit_cnt_r + 3'h1;
          byte_full_r <= (bit_cnt_r == 3'h7);
        end
        TW_RACK: acked_r <= ~pins_s.sda;
        default: acked_r <= acked_r;
      endcase
    end else if (scl_fall) begin
      case (tw_r)
        TW_ADDR: begin
          if (byte_full_r) begin
            byte_full_r <= 1'b0;
            if (shift_r[7:1] == DEV_ADDR) begin
              sda_oe_r <= 1'b1;
              rw_r     <= shift_r[0];
              tw_r     <= TW_AACK;
            end else begin
              tw_r <= TW_IDLE;
            end
          end
        end
        TW_AACK, TW_RACK: begin
          if (tw_r == TW_AACK ? rw_r : acked_r) begin
            tx_r     <= {rd_byte[6:0], 1'b0};
            sda_oe_r <= ~rd_byte[7];
            tw_r     <= TW_RDATA;
          end else if (tw_r == TW_AACK) begin
            sda_oe_r <= 1'b0;
            tw_r     <= TW_WDATA;
          end else begin
            tw_r <= TW_IDLE;
          end
        end
        TW_WDATA: begin
          if (byte_full_r) begin
            byte_full_r <= 1'b0;
            sda_oe_r    <= 1'b1;
            tw_r        <= TW_WACK;
            if (first_r) begin
              ptr_r   <= shift_r[PTR_W-1:0];
              first_r <= 1'b0;
            end else begin
              wr_pulse_r <= 1'b1;
              wr_addr_r  <= ptr_r;
              wr_data_r  <= shift_r;
              ptr_r      <= ptr_r + 1'b1;
            end
          end
        end
        TW_WACK: begin
          sda_oe_r <= 1'b0;
          tw_r     <= TW_WDATA;
        end
        TW_RDATA: begin
          if (byte_full_r) begin
            byte_full_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            tw_r        <= TW_RACK;
            rd_done_r   <= 1'b1;
            rd_addr_r   <= ptr_r;
            ptr_r       <= ptr_r + 1'b1;
          end else begin
            sda_oe_r <= ~tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        end
        default: tw_r <= TW_IDLE;
      endcase
    end
  end

endmodule // pmc_ctrl

// file: verification/pmc_ctrl_monitor.sv
/*
  pmc_ctrl_monitor: port-level assertions and covers for pmc_ctrl.
  Assumes one clock domain, synchronous active-low rst_n, bound to the top.
*/
`timescale 1ns/1ps
module pmc_ctrl_monitor
  import pmc_pkg::*;
#(
  parameter int MIN_PULSE = 4,
  parameter int INIT_TIME = 4
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // two-wire bus
  input wire logic                 twi_scl,
  input wire logic                 twi_sda_i,
  input wire logic                 twi_sda_o,
  input wire logic                 twi_sda_oe,
  // host control
  input wire logic                 module_select_n,
  input wire logic                 module_reset_n,
  input wire logic                 init_control_select,
  input wire logic                 init_control_select_drv,
  // open-drain outputs
  input wire logic                 module_present_n_o,
  input wire logic                 module_present_n_oe,
  input wire logic                 interrupt_out_n_o,
  input wire logic                 interrupt_out_n_oe,
  // events and status
  input wire logic                 fault_event,
  input wire pmc_pkg::pmc_status_t status
);
  // release to ready takes INIT_TIME + 1 cycles; one more for margin
  localparam int INIT_MAX = INIT_TIME + 2;
  // raw pin low time, not cleared by rst_n so a release mid-pulse still counts
  logic [15:0] low_cnt_r = '0;
  always_ff @(posedge clock) begin
    if (module_reset_n) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != 16'hFFFF) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_present; module_present_n_oe && !module_present_n_o; endproperty
  property p_int_od; !interrupt_out_n_o && !twi_sda_o; endproperty
  property p_fault; fault_event |=> interrupt_out_n_oe; endproperty
  property p_desel; module_select_n [*5] |-> !twi_sda_oe; endproperty
  property p_lowpwr; status.data_not_ready |-> !status.high_power; endproperty
  property p_init_undrv; !init_control_select_drv [*4] |-> status.init_sw; endproperty
  property p_filter; $rose(status.data_not_ready) |-> int'(low_cnt_r) > MIN_PULSE; endproperty
  property p_done; $fell(status.data_not_ready) |-> ##[0:2] interrupt_out_n_oe; endproperty
  property p_powerup;
    $rose(rst_n) |-> status.data_not_ready ##[1:INIT_MAX] !status.data_not_ready;
  endproperty
  property p_int_hold;
    $fell(interrupt_out_n_oe) |-> !module_select_n || status.data_not_ready;
  endproperty
  a_present: assert property (p_present) else $error("present line not pulled low");
  a_int_od: assert property (p_int_od) else $error("open-drain output drives high");
  a_fault: assert property (p_fault) else $error("fault did not raise interrupt");
  a_desel: assert property (p_desel) else $error("data line driven while deselected");
  a_lowpwr: assert property (p_lowpwr) else $error("high power before ready");
  a_init_undrv: assert property (p_init_undrv) else $error("undriven init mode not high");
  a_filter: assert property (p_filter) else $error("short reset pulse took effect");
  a_done: assert property (p_done) else $error("no interrupt at reset completion");
  a_powerup: assert property (p_powerup) else $error("no completion after power-up");
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped unread");
  c_fault: cover property (fault_event ##1 interrupt_out_n_oe);
  c_hostrst: cover property ($rose(status.data_not_ready));
  c_clear: cover property ($fell(interrupt_out_n_oe));
endmodule // pmc_ctrl_monitor

bind pmc_ctrl pmc_ctrl_monitor #(.MIN_PULSE(MIN_PULSE), .INIT_TIME(INIT_TIME)) i_mon (
  .clock                   (clock),
  .rst_n                   (rst_n),
  .twi_scl                 (twi_scl),
  .twi_sda_i               (twi_sda_i),
  .twi_sda_o               (twi_sda_o),
  .twi_sda_oe              (twi_sda_oe),
  .module_select_n         (module_select_n),
  .module_reset_n          (module_reset_n),
  .init_control_select     (init_control_select),
  .init_control_select_drv (init_control_select_drv),
  .module_present_n_o      (module_present_n_o),
  .module_present_n_oe     (module_present_n_oe),
  .interrupt_out_n_o       (interrupt_out_n_o),
  .interrupt_out_n_oe      (interrupt_out_n_oe),
  .fault_event             (fault_event),
  .status                  (status)
);

// file: verification/pmc_host_model.sv
/*
  pmc_host_model: host controller on the two-wire bus, open-drain data.
  Assumes a pull-up on data and that the device drives only via its enable.
*/
`timescale 1ns/1ps
module pmc_host_model (
  // clock
  input wire logic clock,
  // bus
  input wire logic dev_sda_oe,
  output logic     scl,
  output logic     sda
);
  logic pull_r = 1'b0;
  // released line floats to the pull-up level
  assign sda = !(pull_r || dev_sda_oe);
  initial scl = 1'b1;
  // six clocks a phase, above what the synchroniser needs
  task automatic half;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task automatic start;
    pull_r = 1'b0;
    half;
    scl = 1'b1;
    half;
    pull_r = 1'b1;
    half;
    scl = 1'b0;
  endtask
  task automatic stop;
    pull_r = 1'b1;
    half;
    scl = 1'b1;
    half;
    pull_r = 1'b0;
    half;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic byte9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      pull_r = !d[i];
      half;
      scl = 1'b1;
      half;
      q[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule // pmc_host_model

// file: verification/pmc_ctrl_tb.sv
/*
  pmc_ctrl_tb: self-checking bench for pmc_ctrl with the host bus model.
  Assumes short MIN_PULSE and INIT_TIME so resets complete quickly.
*/
`timescale 1ns/1ps
module pmc_ctrl_tb;
  import pmc_pkg::*;
  localparam int MP = 4;
  localparam int IT = 4;
  logic        clock   = 1'b0;
  logic        rst_n   = 1'b0;
  logic        sel_n   = 1'b1;
  logic        mrst_n  = 1'b1;
  logic        ini     = 1'b0;
  logic        ini_drv = 1'b0;
  logic        fault   = 1'b0;
  logic        scl, sda, sda_o, sda_oe, prs_o, prs_oe, int_o, int_oe, ak;
  logic [7:0]  q;
  logic [15:0] w;
  pmc_status_t st;
  int          bad_count   = 0;
  int          check_count = 0;
  // pointer, byte written, byte read back
  logic [23:0] rows [6] = '{24'h04A5A5, 24'h0F5A5A, 24'h00FF00, 24'h030002,
                            24'h020101, 24'h03FF03};
  pmc_ctrl #(.MIN_PULSE(MP), .INIT_TIME(IT)) i_dut (
    .clock(clock), .rst_n(rst_n), .twi_scl(scl), .twi_sda_i(sda),
    .twi_sda_o(sda_o), .twi_sda_oe(sda_oe), .module_select_n(sel_n),
    .module_reset_n(mrst_n), .init_control_select(ini),
    .init_control_select_drv(ini_drv), .module_present_n_o(prs_o),
    .module_present_n_oe(prs_oe), .interrupt_out_n_o(int_o),
    .interrupt_out_n_oe(int_oe), .fault_event(fault), .status(st));
  pmc_host_model i_host (.clock(clock), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
  always #5 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // status is meaningless until not-ready clears
  task automatic wait_rdy;
    for (int i = 0; i < 50 && st.data_not_ready !== 1'b0; i++) tick(1);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic a);
    logic [8:0] r;
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b01}, r);
    a = r[0];
    i_host.byte9({p, 1'b1}, r);
    i_host.byte9({d, 1'b1}, r);
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r;
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b01}, r);
    i_host.byte9({p, 1'b1}, r);
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b11}, r);
    i_host.byte9(9'h1FF, r);
    i_host.stop();
    d = r[8:1];
  endtask
  // two data bytes in one transfer, pointer auto-increments
  task automatic wr2(input logic [7:0] p, input logic [15:0] d);
    logic [8:0] r;
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b01}, r);
    i_host.byte9({p, 1'b1}, r);
    i_host.byte9({d[15:8], 1'b1}, r);
    i_host.byte9({d[7:0], 1'b1}, r);
    i_host.stop();
  endtask
  // first byte acked by the host, second one refused
  task automatic rd2(input logic [7:0] p, output logic [15:0] d);
    logic [8:0] r;
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b01}, r);
    i_host.byte9({p, 1'b1}, r);
    i_host.start();
    i_host.byte9({DEV_ADDR, 2'b11}, r);
    i_host.byte9(9'h1FE, r);
    d[15:8] = r[8:1];
    i_host.byte9(9'h1FF, r);
    i_host.stop();
    d[7:0] = r[8:1];
  endtask
  initial begin
    #(50000 * 10);
    bad_count++;
    final_report();
  end
  initial begin
    tick(6);
    rst_n = 1'b1;
    wait_rdy();
    chk(8'h00, st.data_not_ready);
    chk(8'h01, int_oe);
    chk(8'h01, prs_oe & ~prs_o);
    chk(8'h01, st.init_sw);
    sel_n = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8], ak);
      chk(8'h00, ak);
      rd(rows[i][23:16], q);
      chk(rows[i][7:0], q);
    end
    chk(8'h01, st.high_power);
    // auto-increment on write and read, then wrap from the top address
    wr2(8'h0E, 16'h1122);
    rd2(8'h0E, w);
    chk(8'h11, w[15:8]);
    chk(8'h22, w[7:0]);
    rd2(8'h0F, w);
    chk(8'h22, w[15:8]);
    chk(8'h00, w[7:0]);
    rd(8'h01, q);
    chk(8'h01, q);
    chk(8'h00, int_oe);
    fault = 1'b1;
    tick(1);
    fault = 1'b0;
    tick(1);
    chk(8'h01, int_oe);
    rd(8'h01, q);
    chk(8'h02, q);
    sel_n = 1'b1;
    tick(6);
    wr(8'h04, 8'h00, ak);
    chk(8'h01, ak);
    sel_n = 1'b0;
    tick(6);
    rd(8'h04, q);
    chk(8'hA5, q);
    mrst_n = 1'b0;
    tick(MP);
    mrst_n = 1'b1;
    tick(10);
    rd(8'h04, q);
    chk(8'hA5, q);
    mrst_n = 1'b0;
    tick(MP + 8);
    chk(8'h01, st.data_not_ready);
    chk(8'h00, st.high_power);
    mrst_n = 1'b1;
    wait_rdy();
    chk(8'h01, int_oe);
    rd(8'h04, q);
    chk(8'h00, q);
    rst_n = 1'b0;
    ini_drv = 1'b1;
    tick(6);
    rst_n = 1'b1;
    wait_rdy();
    tick(2);
    chk(8'h01, st.high_power);
    final_report();
  end
endmodule // pmc_ctrl_tb
